/* design/bct_core.sv */
// Device-side command sequencing: bank states, self refresh exit and gear-down,
// read and write strobe preambles, and read preamble training.
// Assumes command pins are sampled on sys_clk, which is the device clock.
`timescale 1ns/1ps

// Operation
// - Gear-down enable waits exit delay per abort bit.
// - Write preamble one or two clocks by mode.
// - Read preamble one or two clocks by mode.
// - Preamble training allowed only in register mode.
// - Training strobe drive begins within bounded delay.
// - Postambles fixed at one clock.
// - Activate latches group, bank and row.
// - Bank idle after precharge time, activate first.
// - Precharge to idle bank accepted, latest restarts.
// - Auto-precharge deferred for restore or stored burst.
module bct_core #(
  parameter int CL = 11,
  parameter int CWL = 9,
  parameter int WR = 12,
  parameter int TMOD_CK = 24
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Command pins
  input wire logic cke,
  input wire logic [2:0] cmd,
  input wire logic cmd_bg,
  input wire logic [1:0] cmd_ba,
  input wire logic [bct_pkg::ROW_W-1:0] cmd_addr,
  // Status control
  input wire logic err_clr,
  input wire logic [2:0] sel_bank,
  // Bank status
  output logic [bct_pkg::NBANK-1:0] bank_open,
  output logic [bct_pkg::NBANK-1:0] bank_idle,
  output logic [bct_pkg::ROW_W-1:0] sel_row,
  // Mode status
  output logic gear_mode,
  output logic in_self_refresh,
  output logic train_on,
  output logic rpre_2ck,
  output logic wpre_2ck,
  output logic gear_err,
  output logic train_err,
  // Read strobe pin
  output logic dqs_out,
  output logic dqs_oe_n,
  // Expected write strobe window
  output logic wdqs_window,
  output logic wdqs_pre
);
  localparam int CW = bct_pkg::CW;
  localparam int NB = bct_pkg::NBANK;
  localparam int RW = bct_pkg::ROW_W;
  localparam int SDO_CYC = TMOD_CK + bct_pkg::SDO_EXTRA_CYC;
  localparam int WR_AP_CYC = CWL + bct_pkg::BURST_CK + WR;
  localparam logic [CW-1:0] SDO_LD = CW'(SDO_CYC - 2);
  localparam logic [CW-1:0] XS_LD = CW'(bct_pkg::TXS_CYC - 1);
  localparam logic [CW-1:0] XSA_LD = CW'(bct_pkg::TXS_ABORT_CYC - 1);
  localparam logic [CW-1:0] CL_LAT = CW'(CL);
  localparam logic [CW-1:0] CWL_LAT = CW'(CWL);
  localparam int sdo_bound = SDO_CYC - 1;
  localparam int rd2_at = CL - 2;
  localparam int rd1_at = CL - 1;
  localparam int wr2_at = CWL - 2;
  localparam int wr1_at = CWL - 1;

  if (CL < 4 || CWL < 4 || CL > 200 || CWL > 200 || WR < 1 || TMOD_CK < 1
      || WR_AP_CYC > 250 || SDO_CYC > 250) begin : g_bad_param
    $error("Latency parameters out of the supported range.");
  end

  typedef struct packed {
    logic cke_d;
    logic in_sr;
    logic xs_done;
    logic [CW-1:0] xs_cnt;
    logic abort;
    logic mpr;
    logic gear;
    logic rpre2;
    logic wpre2;
    logic train;
    logic train_drv;
    logic [CW-1:0] sdo_cnt;
    logic gear_err;
    logic train_err;
    logic [RW-1:0] sel_row;
  } bct_core_reg_t;

  bct_core_reg_t q;
  bct_core_reg_t next_q;

  logic [2:0] bank_idx;
  logic is_mrs3;
  logic is_mrs4;
  logic gear_req;
  logic xs_ok;
  logic rd_go;
  logic wr_go;
  logic [RW-1:0] rows [NB];
  logic rd_busy;
  logic rd_drive;
  logic rd_lvl;
  logic rpre_ph;
  logic wr_busy;

  assign bank_idx = {cmd_bg, cmd_ba};
  assign is_mrs3 = (cmd == bct_pkg::CMD_MRS) && (bank_idx == bct_pkg::MR_SEL3);
  assign is_mrs4 = (cmd == bct_pkg::CMD_MRS) && (bank_idx == bct_pkg::MR_SEL4);
  assign gear_req = is_mrs3 && cmd_addr[bct_pkg::MR3_GEAR_BIT] && !q.gear;
  assign xs_ok = q.xs_done || (q.xs_cnt == '0);
  assign rd_go = (cmd == bct_pkg::CMD_RD);
  assign wr_go = (cmd == bct_pkg::CMD_WR);

  // One state machine per bank; precharge with the auto-precharge bit closes all.
  for (genvar i = 0; i < NB; i++) begin : g_bank
    bct_bank #(
      .WR_AP_CYC(WR_AP_CYC)
    ) u_bank (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .act((cmd == bct_pkg::CMD_ACT) && (bank_idx == 3'(i))),
      .pre((cmd == bct_pkg::CMD_PRE)
        && (cmd_addr[bct_pkg::AP_BIT] || bank_idx == 3'(i))),
      .rd(rd_go && (bank_idx == 3'(i))),
      .wr(wr_go && (bank_idx == 3'(i))),
      .ap(cmd_addr[bct_pkg::AP_BIT]),
      .row_in(cmd_addr),
      .is_open(bank_open[i]),
      .is_idle(bank_idle[i]),
      .row(rows[i])
    );
  end

  bct_strobe u_rd_strobe (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(rd_go),
    .two_ck(q.rpre2),
    .lat(CL_LAT),
    .busy(rd_busy),
    .drive(rd_drive),
    .lvl(rd_lvl),
    .pre_ph(rpre_ph),
    .post_ph()
  );

  bct_strobe u_wr_strobe (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(wr_go),
    .two_ck(q.wpre2),
    .lat(CWL_LAT),
    .busy(wr_busy),
    .drive(wdqs_window),
    .lvl(),
    .pre_ph(wdqs_pre),
    .post_ph()
  );

  always_comb begin
    next_q = q;
    next_q.cke_d = cke;
    next_q.sel_row = rows[sel_bank];
    if (err_clr) begin
      next_q.gear_err = 1'b0;
      next_q.train_err = 1'b0;
    end
    if (!q.xs_done) begin
      if (q.xs_cnt == '0) begin
        next_q.xs_done = 1'b1;
      end else begin
        next_q.xs_cnt = q.xs_cnt - 1'b1;
      end
    end
    // Self refresh entry also drops the device back to the full-rate mode.
    if (cmd == bct_pkg::CMD_SRE) begin
      next_q.in_sr = 1'b1;
      next_q.gear = 1'b0;
    end
    if (q.in_sr && cke && !q.cke_d) begin
      next_q.in_sr = 1'b0;
      next_q.xs_done = 1'b0;
      next_q.xs_cnt = q.abort ? XSA_LD : XS_LD;
    end
    if (is_mrs3) begin
      next_q.mpr = cmd_addr[bct_pkg::MR3_MPR_BIT];
      if (!cmd_addr[bct_pkg::MR3_MPR_BIT]) begin
        next_q.train = 1'b0;
        next_q.train_drv = 1'b0;
      end
    end
    if (gear_req) begin
      if (xs_ok) begin
        next_q.gear = 1'b1;
      end else begin
        next_q.gear_err = 1'b1;
      end
    end
    if (is_mrs4) begin
      next_q.abort = cmd_addr[bct_pkg::MR4_ABORT_BIT];
      next_q.rpre2 = cmd_addr[bct_pkg::MR4_RPRE_BIT];
      next_q.wpre2 = cmd_addr[bct_pkg::MR4_WPRE_BIT];
      next_q.train = 1'b0;
      next_q.train_drv = 1'b0;
      if (cmd_addr[bct_pkg::MR4_TRAIN_BIT]) begin
        if (q.mpr) begin
          next_q.train = 1'b1;
          next_q.sdo_cnt = SDO_LD;
        end else begin
          next_q.train_err = 1'b1;
        end
      end
    end
    if (q.train && !q.train_drv) begin
      if (q.sdo_cnt == '0) begin
        next_q.train_drv = 1'b1;
      end else begin
        next_q.sdo_cnt = q.sdo_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.xs_done <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign gear_mode = q.gear;
  assign in_self_refresh = q.in_sr;
  assign train_on = q.train;
  assign rpre_2ck = q.rpre2;
  assign wpre_2ck = q.wpre2;
  assign gear_err = q.gear_err;
  assign train_err = q.train_err;
  assign sel_row = q.sel_row;
  // Training holds the strobe in its preamble level; reads are not expected then.
  assign dqs_out = q.train_drv ? 1'b0 : rd_lvl;
  assign dqs_oe_n = !(q.train_drv || rd_drive);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  gear_gate_a: assert property (gear_req && !xs_ok |=> !gear_mode && gear_err)
    else $error("Gear-down accepted before the exit delay.");
  gear_take_a: assert property (gear_req && xs_ok |=> gear_mode)
    else $error("Gear-down not taken after the exit delay.");
  train_gate_a: assert property ($rose(train_on) |-> $past(q.mpr))
    else $error("Training enabled outside register mode.");
  sdo_a: assert property ($rose(train_on) |-> ##[0:sdo_bound] !dqs_oe_n)
    else $error("Training strobe not driven in time.");
  rpre_long_a: assert property (rd_go && !rd_busy && q.rpre2 |->
      ##rd2_at rpre_ph ##1 rpre_ph ##1 !rpre_ph)
    else $error("Two-clock read preamble misplaced.");
  rpre_short_a: assert property (rd_go && !rd_busy && !q.rpre2 |->
      ##rd1_at rpre_ph ##1 !rpre_ph)
    else $error("One-clock read preamble misplaced.");
  wpre_long_a: assert property (wr_go && !wr_busy && q.wpre2 |->
      ##wr2_at wdqs_pre ##1 wdqs_pre ##1 !wdqs_pre)
    else $error("Two-clock write preamble misplaced.");
  wpre_short_a: assert property (wr_go && !wr_busy && !q.wpre2 |->
      ##wr1_at wdqs_pre ##1 !wdqs_pre)
    else $error("One-clock write preamble misplaced.");

  // The training refusal, precharge-all, self refresh entry, the abort exit delay and the training strobe level.
  train_refuse_a: assert property (is_mrs4 && cmd_addr[bct_pkg::MR4_TRAIN_BIT] && !q.mpr
      |=> train_err && !train_on)
    else $error("Training enable accepted outside register mode.");
  pre_all_a: assert property (cmd == bct_pkg::CMD_PRE && cmd_addr[bct_pkg::AP_BIT]
      |=> bank_open == '0)
    else $error("Precharge-all left a bank open.");
  sr_gear_a: assert property (cmd == bct_pkg::CMD_SRE |=> in_self_refresh && !gear_mode)
    else $error("Self refresh entry did not drop gear-down.");
  xs_abort_a: assert property (q.in_sr && cke && !q.cke_d && q.abort |=> xs_ok)
    else $error("Abort exit delay not applied.");
  train_drive_a: assert property (q.train_drv |-> !dqs_oe_n && !dqs_out)
    else $error("Training strobe not held at its preamble level.");
  train_cov: cover property ($rose(train_on) ##[1:40] !dqs_oe_n);
  gear_cov: cover property (in_self_refresh ##[1:20] gear_req && xs_ok);
  rd_long_cov: cover property (rd_go && !rd_busy && q.rpre2);

endmodule // bct_core

/* pkg/bct_pkg.sv */
// Constants and types of the bank command timing and strobe preamble block.
// Assumes one 25 MHz device clock on which commands are also sampled.
package bct_pkg;

  // Clock period and documented times, each in its own unit.
  localparam int CLK_PS = 40000;
  localparam int TRP_NS = 14;
  localparam int TRAS_NS = 32;
  localparam int TXS_NS = 170;
  localparam int TXS_ABORT_NS = 30;
  localparam int SDO_EXTRA_NS = 9;

  // Least times round up, longest times round down, never below one cycle.
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max_cyc(input int ns);
    int c;
    c = (ns * 1000) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int TRP_CYC = min_cyc(TRP_NS);
  localparam int TRAS_CYC = min_cyc(TRAS_NS);
  localparam int TXS_CYC = min_cyc(TXS_NS);
  localparam int TXS_ABORT_CYC = min_cyc(TXS_ABORT_NS);
  localparam int SDO_EXTRA_CYC = max_cyc(SDO_EXTRA_NS);

  localparam int BURST_CK = 4;
  localparam int PRE_SHORT_CK = 1;
  localparam int PRE_LONG_CK = 2;
  localparam int CW = 8;
  localparam int ROW_W = 18;
  localparam int NBANK = 8;

  // Mode register selects and address bit positions.
  localparam logic [2:0] MR_SEL3 = 3'h3;
  localparam logic [2:0] MR_SEL4 = 3'h4;
  localparam int MR3_MPR_BIT = 2;
  localparam int MR3_GEAR_BIT = 3;
  localparam int MR4_ABORT_BIT = 9;
  localparam int MR4_TRAIN_BIT = 10;
  localparam int MR4_RPRE_BIT = 11;
  localparam int MR4_WPRE_BIT = 12;
  localparam int AP_BIT = 10;

  typedef enum logic [2:0] {
    CMD_DES = 3'h0, CMD_MRS = 3'h1, CMD_ACT = 3'h2, CMD_RD = 3'h3,
    CMD_WR = 3'h4, CMD_PRE = 3'h5, CMD_REF = 3'h6, CMD_SRE = 3'h7
  } bct_cmd_t;

  typedef enum logic [1:0] {
    BK_IDLE = 2'h0, BK_ACTIVE = 2'h1, BK_APWAIT = 2'h3, BK_PRECHG = 2'h2
  } bct_bank_st_t;

  typedef enum logic [2:0] {
    SB_IDLE = 3'h0, SB_WAIT = 3'h1, SB_PRE = 3'h3, SB_BURST = 3'h2, SB_POST = 3'h6
  } bct_strobe_st_t;

endpackage

/* design/bct_bank.sv */
// One bank: open row, precharge timing and auto-precharge deferral.
// Assumes decoded one-cycle command strobes on the device clock.
`timescale 1ns/1ps
module bct_bank #(
  parameter int WR_AP_CYC = 25
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Decoded commands for this bank
  input wire logic act,
  input wire logic pre,
  input wire logic rd,
  input wire logic wr,
  input wire logic ap,
  input wire logic [bct_pkg::ROW_W-1:0] row_in,
  // Bank status
  output logic is_open,
  output logic is_idle,
  output logic [bct_pkg::ROW_W-1:0] row
);
  localparam int CW = bct_pkg::CW;
  localparam logic [CW-1:0] TRP_LD = CW'(bct_pkg::TRP_CYC - 1);
  localparam logic [CW-1:0] TRAS_LD = CW'(bct_pkg::TRAS_CYC - 1);
  localparam logic [CW-1:0] WRAP_LD = CW'(WR_AP_CYC - 1);
  localparam logic [CW-1:0] TRP_CHK = CW'(bct_pkg::TRP_CYC);
  localparam logic [CW-1:0] TRAS_CHK = CW'(bct_pkg::TRAS_CYC);
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [CW-1:0] CNT_MAX = '1;

  typedef struct packed {
    bct_pkg::bct_bank_st_t st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] ras_cnt;
    logic [CW-1:0] since_pre;
    logic [CW-1:0] since_act;
    logic [bct_pkg::ROW_W-1:0] row;
  } bct_bank_reg_t;

  bct_bank_reg_t q;
  bct_bank_reg_t next_q;

  assign is_open = (q.st == bct_pkg::BK_ACTIVE) || (q.st == bct_pkg::BK_APWAIT);
  assign is_idle = (q.st == bct_pkg::BK_IDLE) || (q.st == bct_pkg::BK_PRECHG && q.cnt == '0);
  assign row = q.row;

  always_comb begin
    next_q = q;
    if (q.cnt != '0) begin
      next_q.cnt = q.cnt - 1'b1;
    end
    if (q.ras_cnt != '0) begin
      next_q.ras_cnt = q.ras_cnt - 1'b1;
    end
    if (q.since_pre != CNT_MAX) begin
      next_q.since_pre = q.since_pre + 1'b1;
    end
    if (q.since_act != CNT_MAX) begin
      next_q.since_act = q.since_act + 1'b1;
    end
    unique case (q.st)
      bct_pkg::BK_IDLE: begin
        next_q.st = bct_pkg::BK_IDLE;
      end
      bct_pkg::BK_ACTIVE: begin
        if (pre) begin
          next_q.st = bct_pkg::BK_PRECHG;
          next_q.cnt = TRP_LD;
        end else if ((rd || wr) && ap) begin
          // Reads wait only for the restore time, writes for the stored burst.
          next_q.st = bct_pkg::BK_APWAIT;
          next_q.cnt = wr ? WRAP_LD : '0;
        end
      end
      bct_pkg::BK_APWAIT: begin
        if (pre || (q.cnt == '0 && q.ras_cnt == '0)) begin
          next_q.st = bct_pkg::BK_PRECHG;
          next_q.cnt = TRP_LD;
        end
      end
      bct_pkg::BK_PRECHG: begin
        if (pre) begin
          next_q.cnt = TRP_LD;
        end else if (q.cnt == '0) begin
          next_q.st = bct_pkg::BK_IDLE;
        end
      end
    endcase
    if (next_q.st == bct_pkg::BK_PRECHG && (q.st != bct_pkg::BK_PRECHG || pre)) begin
      next_q.since_pre = ONE;
    end
    if (act && is_idle) begin
      next_q.st = bct_pkg::BK_ACTIVE;
      next_q.row = row_in;
      next_q.ras_cnt = TRAS_LD;
      next_q.since_act = ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  open_row_a: assert property (act && is_idle |=> is_open && row == $past(row_in))
    else $error("Activate did not open the addressed row.");
  idle_trp_a: assert property ($rose(is_idle) |-> q.since_pre == TRP_CHK)
    else $error("Bank became idle at the wrong time after precharge.");
  ap_ras_a: assert property ($rose(q.st == bct_pkg::BK_PRECHG) && $past(q.st) == bct_pkg::BK_APWAIT
      && !$past(pre) |-> q.since_act > TRAS_CHK)
    else $error("Auto-precharge started before the restore time.");
  ap_cov: cover property (act ##[1:20] (rd && ap));

endmodule // bct_bank

/* design/bct_strobe.sv */
// Strobe sequencer: wait, preamble of one or two clocks, burst, postamble.
// Assumes a start pulse per column command and a latency of at least four.
`timescale 1ns/1ps
module bct_strobe (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Start request
  input wire logic start,
  input wire logic two_ck,
  input wire logic [bct_pkg::CW-1:0] lat,
  // Strobe phases
  output logic busy,
  output logic drive,
  output logic lvl,
  output logic pre_ph,
  output logic post_ph
);
  localparam int CW = bct_pkg::CW;
  localparam logic [CW-1:0] LONG_LD = CW'(bct_pkg::PRE_LONG_CK - 1);
  localparam logic [CW-1:0] SHORT_LD = CW'(bct_pkg::PRE_SHORT_CK - 1);
  localparam logic [CW-1:0] BURST_LD = CW'(bct_pkg::BURST_CK - 1);
  // The start edge and the last wait cycle both count against the latency.
  localparam logic [CW-1:0] LEAD = CW'(2);
  localparam logic [CW-1:0] LONG_W = CW'(bct_pkg::PRE_LONG_CK);
  localparam logic [CW-1:0] SHORT_W = CW'(bct_pkg::PRE_SHORT_CK);

  typedef struct packed {
    bct_pkg::bct_strobe_st_t st;
    logic two;
    logic lvl;
    logic [CW-1:0] cnt;
  } bct_strobe_reg_t;

  bct_strobe_reg_t q;
  bct_strobe_reg_t next_q;

  assign busy = (q.st != bct_pkg::SB_IDLE);
  assign pre_ph = (q.st == bct_pkg::SB_PRE);
  assign post_ph = (q.st == bct_pkg::SB_POST);
  assign drive = pre_ph || post_ph || (q.st == bct_pkg::SB_BURST);
  assign lvl = q.lvl;

  always_comb begin
    next_q = q;
    unique case (q.st)
      bct_pkg::SB_IDLE: begin
        if (start) begin
          next_q.st = bct_pkg::SB_WAIT;
          next_q.two = two_ck;
          next_q.cnt = lat - (two_ck ? LONG_W : SHORT_W) - LEAD;
        end
      end
      bct_pkg::SB_WAIT: begin
        if (q.cnt == '0) begin
          next_q.st = bct_pkg::SB_PRE;
          next_q.cnt = q.two ? LONG_LD : SHORT_LD;
          next_q.lvl = 1'b0;
        end else begin
          next_q.cnt = q.cnt - 1'b1;
        end
      end
      bct_pkg::SB_PRE: begin
        if (q.cnt == '0) begin
          next_q.st = bct_pkg::SB_BURST;
          next_q.cnt = BURST_LD;
          next_q.lvl = 1'b1;
        end else begin
          next_q.cnt = q.cnt - 1'b1;
        end
      end
      bct_pkg::SB_BURST: begin
        next_q.lvl = ~q.lvl;
        if (q.cnt == '0) begin
          next_q.st = bct_pkg::SB_POST;
          next_q.lvl = 1'b0;
        end else begin
          next_q.cnt = q.cnt - 1'b1;
        end
      end
      bct_pkg::SB_POST: begin
        next_q.st = bct_pkg::SB_IDLE;
      end
      default: begin
        next_q.st = bct_pkg::SB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  burst_post_a: assert property ($rose(q.st == bct_pkg::SB_BURST) |->
      (q.st == bct_pkg::SB_BURST)[*4] ##1 (post_ph && !lvl) ##1 !drive)
    else $error("Burst or postamble length is wrong.");
  post_cov: cover property ($rose(post_ph) && q.two);

endmodule // bct_strobe

/* verification/bct_ctrl_model.sv */
// Behavioural memory controller driving the command pins of the block.
// Assumes its tasks are called one at a time from the bench's main process.
`timescale 1ns/1ps
module bct_ctrl_model #(
  parameter int TCCD_S = 4,
  parameter int TCCD_L = 6,
  parameter int TRRD_S = 4,
  parameter int TRRD_L = 6,
  parameter int TFAW = 20,
  parameter int WTR_GAP = 20,
  parameter int SYNC_GEAR = 4
) (
  // Clock
  input wire logic sys_clk,
  // Command pins
  output logic cke,
  output logic [2:0] cmd,
  output logic cmd_bg,
  output logic [1:0] cmd_ba,
  output logic [bct_pkg::ROW_W-1:0] cmd_addr
);
  int cyc = 0;
  int col_t = -100;
  int wr_t = -100;
  int act_t [4] = '{default: -100};
  logic col_bg = 1'b0;
  logic act_bg = 1'b0;
  logic train = 1'b0;
  logic [7:0] opened = 8'h00;
  logic [bct_pkg::ROW_W-1:0] open_row [8];

  initial begin
    cke = 1'b1;
    cmd = bct_pkg::CMD_DES;
    cmd_bg = 1'b0;
    cmd_ba = 2'h0;
    cmd_addr = 18'h00000;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  task automatic set_cke(input logic v);
    @(posedge sys_clk);
    #1 cke = v;
  endtask

  task automatic issue(input logic [2:0] c, input logic [2:0] bank, input logic [17:0] a);
    int e;
    e = 0;
    if (c == bct_pkg::CMD_RD && train) return;
    if (c == bct_pkg::CMD_ACT && opened[bank] && open_row[bank] != a) return;
    if (c == bct_pkg::CMD_RD || c == bct_pkg::CMD_WR) begin
      e = col_t + ((bank[2] == col_bg) ? TCCD_L : TCCD_S);
    end
    if (c == bct_pkg::CMD_RD && wr_t + WTR_GAP > e) e = wr_t + WTR_GAP;
    if (c == bct_pkg::CMD_ACT) begin
      e = act_t[0] + ((bank[2] == act_bg) ? TRRD_L : TRRD_S);
      if (act_t[3] + TFAW > e) e = act_t[3] + TFAW;
    end
    @(posedge sys_clk);
    #1;
    while (cyc < e) begin
      @(posedge sys_clk);
      #1;
    end
    cmd = c;
    {cmd_bg, cmd_ba} = bank;
    cmd_addr = a;
    if (c == bct_pkg::CMD_RD || c == bct_pkg::CMD_WR) begin
      col_t = cyc;
      col_bg = bank[2];
      if (a[10]) opened[bank] = 1'b0;
    end
    if (c == bct_pkg::CMD_WR) wr_t = cyc;
    if (c == bct_pkg::CMD_ACT) begin
      act_t = '{cyc, act_t[0], act_t[1], act_t[2]};
      act_bg = bank[2];
      opened[bank] = 1'b1;
      open_row[bank] = a;
    end
    if (c == bct_pkg::CMD_PRE) begin
      if (a[10]) opened = 8'h00;
      else opened[bank] = 1'b0;
    end
    if (c == bct_pkg::CMD_MRS && bank == 3'h4) train = a[10];
    @(posedge sys_clk);
    #1 cmd = bct_pkg::CMD_DES;
    cmd_addr = ~a;
    // Only deselects for an even count after the gear-down write.
    if (c == bct_pkg::CMD_MRS && bank == 3'h3 && a[3]) begin
      repeat (SYNC_GEAR) @(posedge sys_clk);
      #1;
    end
  endtask
endmodule // bct_ctrl_model

/* verification/bct_core_tb.sv */
// Self-checking bench of the bank command timing and strobe preamble block.
// Assumes the partner controller model and the package defaults of the design.
`timescale 1ns/1ps
module bct_core_tb;
  // Latencies assume a fast speed bin and include the long-preamble increments.
  localparam int CL_T = 11;
  localparam int CWL_T = 9;
  localparam int WR_T = 12;
  localparam int TMOD_T = 24;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic err_clr = 1'b0;
  logic [2:0] sel_bank = 3'h0;
  logic cke;
  logic [2:0] cmd;
  logic cmd_bg;
  logic [1:0] cmd_ba;
  logic [17:0] cmd_addr;
  logic [7:0] bank_open;
  logic [7:0] bank_idle;
  logic [17:0] sel_row;
  logic gear_mode, in_self_refresh, train_on, rpre_2ck, wpre_2ck, gear_err, train_err;
  logic dqs_out, dqs_oe_n, wdqs_window, wdqs_pre;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  always #20 sys_clk = ~sys_clk;

  bct_ctrl_model ctrl_u (.sys_clk(sys_clk), .cke(cke), .cmd(cmd), .cmd_bg(cmd_bg),
    .cmd_ba(cmd_ba), .cmd_addr(cmd_addr));

  bct_core #(.CL(CL_T), .CWL(CWL_T), .WR(WR_T), .TMOD_CK(TMOD_T)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .cke(cke), .cmd(cmd), .cmd_bg(cmd_bg),
    .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .err_clr(err_clr), .sel_bank(sel_bank),
    .bank_open(bank_open), .bank_idle(bank_idle), .sel_row(sel_row),
    .gear_mode(gear_mode), .in_self_refresh(in_self_refresh), .train_on(train_on),
    .rpre_2ck(rpre_2ck), .wpre_2ck(wpre_2ck), .gear_err(gear_err),
    .train_err(train_err), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n),
    .wdqs_window(wdqs_window), .wdqs_pre(wdqs_pre));

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Follows one strobe sequence, one cycle at a time, from the command edge.
  task automatic strobe_chk(input logic rd, input int p);
    int lat;
    lat = rd ? CL_T : CWL_T;
    for (int k = 1; k <= lat + 6; k++) begin
      if (rd) begin
        chk("dqs_oe_n", 32'(!(k >= lat - p && k <= lat + 4)), 32'(dqs_oe_n));
        chk("dqs_out", 32'(k == lat || k == lat + 2), 32'(dqs_out));
      end else begin
        chk("wdqs_window", 32'(k >= lat - p && k <= lat + 4), 32'(wdqs_window));
        chk("wdqs_pre", 32'(k >= lat - p && k < lat), 32'(wdqs_pre));
      end
      step(1);
    end
  endtask

  task automatic self_exit();
    ctrl_u.issue(bct_pkg::CMD_SRE, 3'h0, 18'h00000);
    ctrl_u.set_cke(1'b0);
    step(2);
    ctrl_u.set_cke(1'b1);
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk("bank_idle", 32'hff, 32'(bank_idle));
    chk("dqs_oe_n", 32'h1, 32'(dqs_oe_n));
    sel_bank = 3'h5;
    ctrl_u.issue(bct_pkg::CMD_ACT, 3'h5, 18'h2abcd);
    step(2);
    chk("sel_row", 32'h2abcd, 32'(sel_row));
    chk("bank_open", 32'h20, 32'(bank_open));
    ctrl_u.issue(bct_pkg::CMD_PRE, 3'h5, 18'h00000);
    step(bct_pkg::TRP_CYC + 1);
    chk("bank_idle", 32'hff, 32'(bank_idle));
    ctrl_u.issue(bct_pkg::CMD_PRE, 3'h5, 18'h00400);
    ctrl_u.issue(bct_pkg::CMD_REF, 3'h0, 18'h00000);
    step(bct_pkg::TRP_CYC + 1);
    chk("bank_idle", 32'hff, 32'(bank_idle));
    ctrl_u.issue(bct_pkg::CMD_ACT, 3'h0, 18'h00001);
    step(2);
    ctrl_u.issue(bct_pkg::CMD_RD, 3'h0, 18'h00000);
    strobe_chk(1'b1, 1);
    ctrl_u.issue(bct_pkg::CMD_WR, 3'h0, 18'h00000);
    strobe_chk(1'b0, 1);
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h4, 18'h01800);
    step(2);
    chk("pre_2ck", 32'h3, 32'({rpre_2ck, wpre_2ck}));
    ctrl_u.issue(bct_pkg::CMD_RD, 3'h0, 18'h00000);
    strobe_chk(1'b1, 2);
    ctrl_u.issue(bct_pkg::CMD_WR, 3'h0, 18'h00000);
    strobe_chk(1'b0, 2);
    ctrl_u.issue(bct_pkg::CMD_RD, 3'h0, 18'h00400);
    step(bct_pkg::TRP_CYC + 3);
    chk("bank_idle", 32'hff, 32'(bank_idle));
    step(16);
    ctrl_u.issue(bct_pkg::CMD_ACT, 3'h4, 18'h00003);
    step(2);
    ctrl_u.issue(bct_pkg::CMD_WR, 3'h4, 18'h00400);
    step(CWL_T + 4 + WR_T - 2);
    chk("bank_open", 32'h10, 32'(bank_open));
    step(4 + bct_pkg::TRP_CYC);
    chk("bank_idle", 32'hff, 32'(bank_idle));
    self_exit();
    chk("in_self_refresh", 32'h1, 32'(in_self_refresh));
    chk("gear_mode", 32'h0, 32'(gear_mode));
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h3, 18'h00008);
    step(2);
    chk("gear_err", 32'h1, 32'(gear_err));
    chk("gear_mode", 32'h0, 32'(gear_mode));
    chk("in_self_refresh", 32'h0, 32'(in_self_refresh));
    err_clr = 1'b1;
    step(1);
    err_clr = 1'b0;
    step(1);
    chk("gear_err", 32'h0, 32'(gear_err));
    self_exit();
    step(bct_pkg::TXS_CYC - 1);
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h3, 18'h00008);
    step(1);
    chk("gear_mode", 32'h1, 32'(gear_mode));
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h4, 18'h00200);
    self_exit();
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h3, 18'h00008);
    step(1);
    chk("gear_abort", 32'h2, 32'({gear_mode, gear_err}));
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h4, 18'h00400);
    step(2);
    chk("train_err", 32'h1, 32'({train_on, train_err}));
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h3, 18'h00004);
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h4, 18'h00400);
    step(1);
    chk("train_on", 32'h1, 32'(train_on));
    step(TMOD_T - 2);
    chk("dqs_oe_n", 32'h1, 32'(dqs_oe_n));
    step(1);
    chk("dqs_drive", 32'h0, 32'({dqs_oe_n, dqs_out}));
    ctrl_u.issue(bct_pkg::CMD_MRS, 3'h4, 18'h00000);
    step(2);
    chk("train_off", 32'h1, 32'({train_on, dqs_oe_n}));
    end_sim();
  end
endmodule // bct_core_tb
